// *** inc/slp_pkg.sv ***
/*
 Constants, types and timing counts for the switch, lamp and shutdown sequencer.
 Assumes a 125 MHz system clock and a single synchronous reset.
*/
package slp_pkg;
   // Register offsets, byte addresses on the command port
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] STAT_OFS = 8'h04;
   localparam logic [7:0] FLAG_OFS = 8'h08;
   localparam logic [7:0] MASK_OFS = 8'h0C;
   // Command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_COLOR_BIT = 4;
   localparam logic [3:0] OP_LAMP_ON = 4'h1;
   localparam logic [3:0] OP_LAMP_OFF = 4'h2;
   localparam logic [3:0] OP_ARM = 4'h3;
   localparam logic [3:0] OP_DISARM = 4'h4;
   localparam logic [3:0] OP_BTN_IRQ_EN = 4'h5;
   localparam logic [3:0] OP_BTN_IRQ_DIS = 4'h6;
   localparam logic [3:0] OP_GIRQ_EN = 4'h7;
   localparam logic [3:0] OP_GIRQ_DIS_CLR = 4'h8;
   localparam logic COLOR_RED = 1'b0;
   localparam logic COLOR_GREEN = 1'b1;
   // Status register bits
   localparam int STAT_LEVEL = 0;
   localparam int STAT_ARMED = 1;
   localparam int STAT_BUSY = 2;
   localparam int STAT_OFF = 3;
   localparam int STAT_RED = 4;
   localparam int STAT_GREEN = 5;
   localparam int STAT_GIE = 6;
   localparam int STAT_SHUT_PIN = 7;
   localparam int STAT_IRQ_PIN = 8;
   // Interrupt flag word
   localparam int FLAG_W = 16;
   localparam int FLAG_BTN_BIT = 8;
   localparam logic [FLAG_W-1:0] FLAG_RST = 16'h0000;
   localparam logic [FLAG_W-1:0] MASK_RST = 16'h0000;
   // Timing
   localparam longint unsigned CLK_KHZ = 125000;
   localparam longint unsigned DEBOUNCE_MS = 10;
   localparam longint unsigned HOLD_MS = 5000;
   localparam longint unsigned SETTLE_MS = 15000;
   localparam longint unsigned DEBOUNCE_CYC = DEBOUNCE_MS * CLK_KHZ;
   localparam longint unsigned HOLD_CYC = HOLD_MS * CLK_KHZ;
   localparam longint unsigned SETTLE_CYC = SETTLE_MS * CLK_KHZ;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01,
      ST_SETTLE = 2'b10,
      ST_OFF = 2'b11
   } slp_state_type;

   typedef struct packed {
      logic green;
      logic red;
   } slp_lamp_type;

   localparam slp_lamp_type LAMP_RST = '{green: 1'b1, red: 1'b0};
endpackage

// *** rtl/slp_sequencer.sv ***
/*
 Switch, bicolor lamp and graceful shutdown sequencer with its command registers.
 Assumes synchronous inputs, an external nonvolatile store for the arm bit, and
 open-drain host lines resolved outside from the output enables.
*/
`timescale 1ns/100ps
module slp_sequencer #(
   parameter logic [31:0] DEBOUNCE_CYC = 32'(slp_pkg::DEBOUNCE_CYC),
   parameter logic [31:0] HOLD_CYC = 32'(slp_pkg::HOLD_CYC),
   parameter logic [31:0] SETTLE_CYC = 32'(slp_pkg::SETTLE_CYC)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] boardAddrStrap,
   input wire logic buttonIn,
   input wire logic [2:0] busBoard,
   input wire logic [7:0] busAddr,
   input wire logic [31:0] busWdata,
   input wire logic busWr,
   input wire logic busRd,
   output logic [31:0] busRdata,
   input wire logic nvArmIn,
   output logic nvWrite,
   output logic nvData,
   output slp_pkg::slp_lamp_type lamp,
   input wire logic shutReqIn,
   output logic shutReqOut,
   output logic shutReqOe,
   input wire logic altShutIn,
   output logic altShutOut,
   output logic altShutOe,
   input wire logic hostIrqIn,
   output logic hostIrqOut,
   output logic hostIrqOe
);
   slp_pkg::slp_state_type state_r, state_nxt;
   slp_pkg::slp_lamp_type lamp_r, lamp_nxt;
   logic initDone_r, initDone_nxt;
   logic [2:0] boardId_r, boardId_nxt;
   logic armed_r, armed_nxt;
   logic btnLevel_r, btnLevel_nxt;
   logic [31:0] debCnt_r, debCnt_nxt;
   logic [31:0] seqCnt_r, seqCnt_nxt;
   logic shutOe_r, shutOe_nxt;
   logic irqOe_r, irqOe_nxt;
   logic gie_r, gie_nxt;
   logic [slp_pkg::FLAG_W-1:0] flags_r, flags_nxt;
   logic [slp_pkg::FLAG_W-1:0] mask_r, mask_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic nvWrite_r, nvWrite_nxt;
   logic nvData_r, nvData_nxt;
   logic lineLow_r;

   // True when an access targets this board at the given offset
   function automatic logic hit(input logic [2:0] brd, input logic [2:0] own,
                                input logic [7:0] addr, input logic [7:0] ofs);
      hit = (brd == own) && (addr == ofs);
   endfunction

   // True while the shutdown sequence is holding or settling
   function automatic logic seqBusy(input slp_pkg::slp_state_type st);
      seqBusy = (st == slp_pkg::ST_HOLD) || (st == slp_pkg::ST_SETTLE);
   endfunction

   always_comb begin
      logic press;
      logic [slp_pkg::FLAG_W-1:0] setBits;
      logic [slp_pkg::FLAG_W-1:0] clrBits;
      logic [3:0] op;
      logic color;
      logic wrOk;
      logic rdOk;
      press = 1'b0;
      setBits = '0;
      clrBits = '0;
      op = busWdata[slp_pkg::CMD_OP_LSB +: 4];
      color = busWdata[slp_pkg::CMD_COLOR_BIT];
      wrOk = busWr && initDone_r;
      rdOk = busRd && initDone_r;
      state_nxt = state_r;
      lamp_nxt = lamp_r;
      initDone_nxt = initDone_r;
      boardId_nxt = boardId_r;
      armed_nxt = armed_r;
      btnLevel_nxt = btnLevel_r;
      debCnt_nxt = debCnt_r;
      seqCnt_nxt = seqCnt_r;
      shutOe_nxt = shutOe_r;
      gie_nxt = gie_r;
      mask_nxt = mask_r;
      rdata_nxt = 32'h00000000;
      nvWrite_nxt = 1'b0;
      nvData_nxt = nvData_r;

      // Strap and stored arm bit captured once after reset release
      if (!initDone_r) begin
         initDone_nxt = 1'b1;
         boardId_nxt = boardAddrStrap;
         armed_nxt = nvArmIn;
      end

      // Debounce: a new level must hold for the full interval
      if (buttonIn == btnLevel_r) begin
         debCnt_nxt = 32'h00000000;
      end else if (debCnt_r >= DEBOUNCE_CYC - 32'h00000001) begin
         btnLevel_nxt = buttonIn;
         debCnt_nxt = 32'h00000000;
         press = btnLevel_r && !buttonIn;
      end else begin
         debCnt_nxt = debCnt_r + 32'h00000001;
      end

      // Command register
      if (wrOk && hit(busBoard, boardId_r, busAddr, slp_pkg::CMD_OFS)) begin
         unique case (op)
            slp_pkg::OP_LAMP_ON: begin
               if (color == slp_pkg::COLOR_GREEN) begin
                  lamp_nxt.green = 1'b1;
               end else begin
                  lamp_nxt.red = 1'b1;
               end
            end
            slp_pkg::OP_LAMP_OFF: begin
               if (color == slp_pkg::COLOR_GREEN) begin
                  lamp_nxt.green = 1'b0;
               end else begin
                  lamp_nxt.red = 1'b0;
               end
            end
            slp_pkg::OP_ARM: begin
               armed_nxt = 1'b1;
               nvWrite_nxt = 1'b1;
               nvData_nxt = 1'b1;
            end
            slp_pkg::OP_DISARM: begin
               armed_nxt = 1'b0;
               nvWrite_nxt = 1'b1;
               nvData_nxt = 1'b0;
            end
            slp_pkg::OP_BTN_IRQ_EN: begin
               mask_nxt[slp_pkg::FLAG_BTN_BIT] = 1'b1;
            end
            slp_pkg::OP_BTN_IRQ_DIS: begin
               mask_nxt[slp_pkg::FLAG_BTN_BIT] = 1'b0;
            end
            slp_pkg::OP_GIRQ_EN: begin
               gie_nxt = 1'b1;
            end
            slp_pkg::OP_GIRQ_DIS_CLR: begin
               gie_nxt = 1'b0;
               clrBits = '1;
            end
            default: ;
         endcase
      end
      if (wrOk && hit(busBoard, boardId_r, busAddr, slp_pkg::MASK_OFS)) begin
         mask_nxt = busWdata[slp_pkg::FLAG_W-1:0];
      end
      if (wrOk && hit(busBoard, boardId_r, busAddr, slp_pkg::FLAG_OFS)) begin
         clrBits = clrBits | busWdata[slp_pkg::FLAG_W-1:0];
      end

      // Register reads; other addresses and other boards read zero
      if (rdOk && hit(busBoard, boardId_r, busAddr, slp_pkg::STAT_OFS)) begin
         rdata_nxt[slp_pkg::STAT_LEVEL] = btnLevel_r;
         rdata_nxt[slp_pkg::STAT_ARMED] = armed_r;
         rdata_nxt[slp_pkg::STAT_BUSY] = seqBusy(state_r);
         rdata_nxt[slp_pkg::STAT_OFF] = (state_r == slp_pkg::ST_OFF);
         rdata_nxt[slp_pkg::STAT_RED] = lamp_r.red;
         rdata_nxt[slp_pkg::STAT_GREEN] = lamp_r.green;
         rdata_nxt[slp_pkg::STAT_GIE] = gie_r;
         rdata_nxt[slp_pkg::STAT_SHUT_PIN] = shutReqIn;
         rdata_nxt[slp_pkg::STAT_IRQ_PIN] = hostIrqIn;
      end
      if (rdOk && hit(busBoard, boardId_r, busAddr, slp_pkg::MASK_OFS)) begin
         rdata_nxt[slp_pkg::FLAG_W-1:0] = mask_r;
      end
      if (rdOk && hit(busBoard, boardId_r, busAddr, slp_pkg::FLAG_OFS)) begin
         rdata_nxt[slp_pkg::FLAG_W-1:0] = flags_r;
         clrBits = '1;
      end

      // Shutdown sequence; runs after the bus so it owns the lamp on its steps
      unique case (state_r)
         slp_pkg::ST_IDLE: begin
            if (press && armed_r) begin
               state_nxt = slp_pkg::ST_HOLD;
               seqCnt_nxt = 32'h00000000;
               shutOe_nxt = 1'b1;
               lamp_nxt.red = 1'b1;
               lamp_nxt.green = 1'b1;
            end
         end
         slp_pkg::ST_HOLD: begin
            // Presses are not looked at until the sequence ends
            if (seqCnt_r >= HOLD_CYC - 32'h00000001) begin
               state_nxt = slp_pkg::ST_SETTLE;
               seqCnt_nxt = 32'h00000000;
               shutOe_nxt = 1'b0;
            end else begin
               seqCnt_nxt = seqCnt_r + 32'h00000001;
            end
         end
         slp_pkg::ST_SETTLE: begin
            if (seqCnt_r >= SETTLE_CYC - 32'h00000001) begin
               state_nxt = slp_pkg::ST_OFF;
               seqCnt_nxt = 32'h00000000;
               lamp_nxt.green = 1'b0;
               lamp_nxt.red = 1'b1;
            end else begin
               seqCnt_nxt = seqCnt_r + 32'h00000001;
            end
         end
         slp_pkg::ST_OFF: begin
            if (press) begin
               state_nxt = slp_pkg::ST_IDLE;
               lamp_nxt.green = 1'b1;
               lamp_nxt.red = 1'b0;
            end
         end
      endcase

      // Flags: a press sets only when its enable is on; set wins over clear
      if (press && mask_r[slp_pkg::FLAG_BTN_BIT]) begin
         setBits[slp_pkg::FLAG_BTN_BIT] = 1'b1;
      end
      flags_nxt = (flags_r & ~clrBits) | setBits;
      irqOe_nxt = gie_nxt && |(flags_nxt & mask_nxt);
   end

   // Registers only; every next value except lineLow_r comes from the process above
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= slp_pkg::ST_IDLE;
         lamp_r <= slp_pkg::LAMP_RST;
         initDone_r <= 1'b0;
         boardId_r <= 3'h0;
         armed_r <= 1'b0;
         btnLevel_r <= 1'b1;
         debCnt_r <= 32'h00000000;
         seqCnt_r <= 32'h00000000;
         shutOe_r <= 1'b0;
         irqOe_r <= 1'b0;
         gie_r <= 1'b0;
         flags_r <= slp_pkg::FLAG_RST;
         mask_r <= slp_pkg::MASK_RST;
         rdata_r <= 32'h00000000;
         nvWrite_r <= 1'b0;
         nvData_r <= 1'b0;
         lineLow_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         lamp_r <= lamp_nxt;
         initDone_r <= initDone_nxt;
         boardId_r <= boardId_nxt;
         armed_r <= armed_nxt;
         btnLevel_r <= btnLevel_nxt;
         debCnt_r <= debCnt_nxt;
         seqCnt_r <= seqCnt_nxt;
         shutOe_r <= shutOe_nxt;
         irqOe_r <= irqOe_nxt;
         gie_r <= gie_nxt;
         flags_r <= flags_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
         nvWrite_r <= nvWrite_nxt;
         nvData_r <= nvData_nxt;
         lineLow_r <= 1'b0;
      end
   end

   // Outputs straight from their flops
   assign busRdata = rdata_r;
   assign nvWrite = nvWrite_r;
   assign nvData = nvData_r;
   assign lamp = lamp_r;
   assign shutReqOut = lineLow_r;
   assign shutReqOe = shutOe_r;
   assign altShutOut = lineLow_r;
   assign altShutOe = shutOe_r;
   assign hostIrqOut = lineLow_r;
   assign hostIrqOe = irqOe_r;
endmodule

// *** test/slp_sva.sv ***
/*
 Port checker for the switch, lamp and shutdown sequencer.
 Assumes it is bound to slp_sequencer and runs on its single clock.
*/
`timescale 1ns/100ps
module slp_sva (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] boardAddrStrap,
   input wire logic [2:0] busBoard,
   input wire logic [7:0] busAddr,
   input wire logic [31:0] busWdata,
   input wire logic busWr,
   input wire logic busRd,
   input wire logic [31:0] busRdata,
   input wire slp_pkg::slp_lamp_type lamp,
   input wire logic shutReqOut,
   input wire logic shutReqOe,
   input wire logic altShutOe,
   input wire logic hostIrqOut,
   input wire logic hostIrqOe
);
   wire logic hit = busBoard == boardAddrStrap;
   wire logic cmdWr = busWr && hit && busAddr == slp_pkg::CMD_OFS;
   wire logic [3:0] op = busWdata[3:0];
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_rst; $fell(srst) |-> lamp == slp_pkg::LAMP_RST && !shutReqOe; endproperty
   a_rst: assert property (p_rst)
      else $error("lamp or line wrong after reset");
   property p_other; busRd && !hit |=> busRdata == 32'h0; endproperty
   a_other: assert property (p_other)
      else $error("foreign board read answered");
   property p_alt; altShutOe == shutReqOe; endproperty
   a_alt: assert property (p_alt)
      else $error("alternate line differs");
   property p_od; !shutReqOut && !hostIrqOut; endproperty
   a_od: assert property (p_od)
      else $error("open drain line driven high");
   property p_both; $rose(shutReqOe) |-> lamp == 2'h3 ##1 shutReqOe [*8]; endproperty
   a_both: assert property (p_both)
      else $error("hold start wrong");
   property p_cmd;
      cmdWr && (op == slp_pkg::OP_LAMP_ON || op == slp_pkg::OP_LAMP_OFF) && !shutReqOe
      |=> lamp[$past(busWdata[4])] == ($past(busWdata[3:0]) == slp_pkg::OP_LAMP_ON);
   endproperty
   a_cmd: assert property (p_cmd)
      else $error("lamp command not applied");
   property p_gdis; cmdWr && op == slp_pkg::OP_GIRQ_DIS_CLR |=> !hostIrqOe; endproperty
   a_gdis: assert property (p_gdis)
      else $error("irq after global disable");
   property p_flag;
      busRd && hit && busAddr == slp_pkg::FLAG_OFS |=> busRdata[31:9] == 23'h0;
   endproperty
   a_flag: assert property (p_flag)
      else $error("flag word upper bits set");
   cover property ($rose(shutReqOe));
   cover property ($rose(hostIrqOe));
   cover property (busRd && hit && busAddr == slp_pkg::FLAG_OFS);
endmodule
bind slp_sequencer slp_sva u_sva (.clk, .srst, .boardAddrStrap, .busBoard, .busAddr,
   .busWdata, .busWr, .busRd, .busRdata, .lamp, .shutReqOut, .shutReqOe, .altShutOe,
   .hostIrqOut, .hostIrqOe);

// *** test/slp_host_model.sv ***
/*
 Host side: pulled-up open drain lines and the nonvolatile arm store.
 Assumes the store keeps its bit across the sequencer's resets.
*/
`timescale 1ns/100ps
module slp_host_model (
   input wire logic clk,
   input wire logic shutReqOe,
   input wire logic altShutOe,
   input wire logic hostIrqOe,
   input wire logic nvWrite,
   input wire logic nvData,
   output logic shutReqIn,
   output logic altShutIn,
   output logic hostIrqIn,
   output logic nvArmIn = 1'b0
);
   assign shutReqIn = !shutReqOe;
   assign altShutIn = !altShutOe;
   assign hostIrqIn = !hostIrqOe;
   always @(posedge clk) begin
      if (nvWrite) begin
         nvArmIn <= nvData;
      end
   end
endmodule

// *** test/testbench.sv ***
/*
 Self-checking bench for the sequencer with short timing parameters.
 Assumes the host model resolves the lines and keeps the arm bit.
*/
`timescale 1ns/100ps
module testbench;
   localparam int DB = 4;
   localparam int HD = 20;
   localparam int ST = 30;
   logic clk = 0, srst = 1, buttonIn = 1, busWr = 0, busRd = 0, prevRd = 0;
   logic [2:0] strap = 0, busBoard = 0;
   logic [7:0] busAddr = 0;
   logic [31:0] busWdata = 0, busRdata;
   logic nvArmIn, nvWrite, nvData, shutReqIn, shutReqOut, shutReqOe, altShutIn;
   logic altShutOut, altShutOe, hostIrqIn, hostIrqOut, hostIrqOe;
   slp_pkg::slp_lamp_type lamp;
   logic [31:0] expD[$], expM[$];
   logic [4:0] ops[4] = '{5'h01, 5'h12, 5'h02, 5'h11};
   logic [1:0] lmp[4] = '{2'h3, 2'h1, 2'h0, 2'h2};
   int n_mismatch = 0, num_checks = 0, cyc = 0, n;
   slp_sequencer #(.DEBOUNCE_CYC(32'(DB)), .HOLD_CYC(32'(HD)), .SETTLE_CYC(32'(ST))) uut (
      .clk, .srst, .boardAddrStrap(strap), .buttonIn, .busBoard, .busAddr, .busWdata,
      .busWr, .busRd, .busRdata, .nvArmIn, .nvWrite, .nvData, .lamp, .shutReqIn,
      .shutReqOut, .shutReqOe, .altShutIn, .altShutOut, .altShutOe, .hostIrqIn,
      .hostIrqOut, .hostIrqOe);
   slp_host_model host (.clk, .shutReqOe, .altShutOe, .hostIrqOe, .nvWrite, .nvData,
      .shutReqIn, .altShutIn, .hostIrqIn, .nvArmIn);
   initial forever #4 clk = ~clk;
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task tally_and_finish;
      if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      prevRd <= busRd;
      cyc <= cyc + 1;
      if (cyc == 9000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   always @(negedge clk) if (prevRd) chk(busRdata & expM.pop_front(), expD.pop_front());
   task wr(input logic [2:0] b, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      busBoard <= b;
      busAddr <= a;
      busWdata <= d;
      busWr <= 1'b1;
      @(posedge clk);
      busWr <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      expD.push_back(e);
      expM.push_back(m);
      @(posedge clk);
      busBoard <= strap;
      busAddr <= a;
      busRd <= 1'b1;
      @(posedge clk);
      busRd <= 1'b0;
   endtask
   task cmd(input logic [4:0] c);
      wr(strap, slp_pkg::CMD_OFS, 32'(c));
   endtask
   task press(input int t);
      @(posedge clk) buttonIn <= 1'b0;
      repeat (t) @(posedge clk);
      buttonIn <= 1'b1;
      repeat (DB + 4) @(posedge clk);
   endtask
   initial begin
      strap = 3'($urandom(33177));
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk) chk(32'(lamp), 32'h2);
      for (int b = 0; b < 8; b++) begin
         if (3'(b) != strap) wr(3'(b), slp_pkg::CMD_OFS, 32'h12);
      end
      @(negedge clk) chk(32'(lamp), 32'h2);
      for (int i = 0; i < 4; i++) begin
         cmd(ops[i]);
         @(negedge clk) chk(32'(lamp), 32'(lmp[i]));
      end
      cmd(5'h05);
      cmd(5'h07);
      @(posedge clk) buttonIn <= 1'b0;
      repeat (DB + 4) @(posedge clk);
      rd(slp_pkg::STAT_OFS, 32'h0, 32'h1);
      @(negedge clk) chk(32'(hostIrqOe), 32'h1);
      @(posedge clk) buttonIn <= 1'b1;
      repeat (DB + 4) @(posedge clk);
      rd(slp_pkg::STAT_OFS, 32'h1, 32'h1);
      rd(slp_pkg::FLAG_OFS, 32'h100, 32'hFFFF);
      rd(slp_pkg::FLAG_OFS, 32'h0, 32'hFFFF);
      @(negedge clk) chk(32'(hostIrqOe), 32'h0);
      press(2);
      rd(slp_pkg::FLAG_OFS, 32'h0, 32'hFFFF);
      cmd(5'h06);
      press(DB + 4);
      rd(slp_pkg::FLAG_OFS, 32'h0, 32'hFFFF);
      cmd(5'h05);
      press(DB + 4);
      @(negedge clk) chk(32'(shutReqOe), 32'h0);
      cmd(5'h08);
      @(negedge clk) chk(32'(hostIrqOe), 32'h0);
      rd(slp_pkg::FLAG_OFS, 32'h0, 32'hFFFF);
      cmd(5'h03);
      rd(slp_pkg::STAT_OFS, 32'h2, 32'h2);
      @(posedge clk) buttonIn <= 1'b0;
      n = 0;
      while (shutReqOe !== 1'b1 && n < 50) begin
         @(negedge clk);
         n++;
      end
      chk(32'({lamp, shutReqIn}), 32'h6);
      n = 0;
      while (shutReqOe === 1'b1 && n < 100) begin
         @(posedge clk) buttonIn <= (n > 6 && n < 14) ? 1'b0 : 1'b1;
         @(negedge clk);
         n++;
      end
      chk(32'(n), 32'(HD));
      repeat (ST - 3) @(posedge clk);
      @(negedge clk) chk(32'(lamp), 32'h3);
      repeat (3) @(posedge clk);
      @(negedge clk) chk(32'(lamp), 32'h1);
      press(DB + 4);
      @(negedge clk) chk(32'({lamp, shutReqOe}), 32'h4);
      @(posedge clk) srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(slp_pkg::STAT_OFS, 32'h2, 32'h2);
      cmd(5'h04);
      press(DB + 4);
      @(negedge clk) chk(32'(shutReqOe), 32'h0);
      rd(slp_pkg::STAT_OFS, 32'h0, 32'h2);
      repeat (3) @(posedge clk);
      tally_and_finish();
   end
endmodule
